// file: bench/host_model.sv
`timescale 1ns/1ps
module host_model (
    // clock
    input  wire logic       mclk_i,
    // host bus toward the block
    output logic            host_wr_o,
    output logic            host_rd_o,
    output logic            sel_o,
    output logic [7:0]      data_o
);
    initial begin
        host_wr_o = 1'b0;
        host_rd_o = 1'b0;
        sel_o     = 1'b1;
        data_o    = 8'hA5;
    end

    ////////////////////////////////////////
    // one strobe cycle; on release the strobes drop low and select and data show the inverse so a stale byte never looks valid
    task automatic xfer(input logic wr, input logic rd, input logic sel, input logic [7:0] d);
        @(posedge mclk_i);
        #1;
        host_wr_o = wr;
        host_rd_o = rd;
        sel_o     = sel;
        data_o    = d;
        @(posedge mclk_i);
        #1;
        host_wr_o = 1'b0;
        host_rd_o = 1'b0;
        sel_o     = ~sel;
        data_o    = ~d;
        @(posedge mclk_i);
        #1;
    endtask

    // command byte and display data cycles
    task automatic cmd(input logic [7:0] d);
        xfer(1'b1, 1'b0, 1'b0, d);
    endtask
    task automatic dwr();
        xfer(1'b1, 1'b0, 1'b1, 8'h5A);
    endtask
    task automatic drd();
        xfer(1'b0, 1'b1, 1'b1, 8'h00);
    endtask
    // open and close always go as a pair
    task automatic rmw_close();
        cmd(8'hEE);
    endtask
endmodule

// file: bench/lcd_cmd_assertions.sv
`timescale 1ns/1ps
module lcd_cmd_assertions (
    // clock, reset and host bus
    input wire logic       mclk_i,
    input wire logic       rst_n_i,
    input wire logic       host_wr_i,
    input wire logic       host_rd_i,
    input wire logic       cmd_data_select_i,
    input wire logic [7:0] host_data_i,
    // watched outputs
    input wire logic [5:0] start_line_o,
    input wire logic [7:0] column_addr_o,
    input wire logic [3:0] page_addr_o,
    input wire logic       rmw_active_o,
    input wire logic       scan_reverse_o,
    input wire logic [2:0] power_ctrl_o,
    input wire logic       follower_en_o,
    input wire logic       regulator_en_o,
    input wire logic       booster_en_o,
    input wire logic [4:0] contrast_level_o,
    input wire logic       contrast_suppressed_o,
    input wire logic       sleep_o,
    input wire logic       standby_o,
    input wire logic       outputs_grounded_o,
    input wire logic       test_mode_o
);
    // a command is only a write with select low
    wire logic cmd_w = host_wr_i && !cmd_data_select_i;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    ////////////////////////////////////////
    chk_rmw_open: assert property (cmd_w && host_data_i == 8'hE0 |=> rmw_active_o)
        else $error("rmw mode not opened");
    chk_rmw_read_hold: assert property (rmw_active_o && host_rd_i && cmd_data_select_i
        && !host_wr_i |=> $stable(column_addr_o))
        else $error("read advanced column in rmw");
    chk_rmw_close: assert property (cmd_w && host_data_i == 8'hEE |=> !rmw_active_o)
        else $error("rmw mode not closed");
    chk_soft_clear: assert property (cmd_w && host_data_i == 8'hE2 |=> start_line_o == 6'h00
        && column_addr_o == 8'h00 && page_addr_o == 4'h0 && !scan_reverse_o && !test_mode_o)
        else $error("soft reset left state");
    chk_soft_power: assert property (cmd_w && host_data_i == 8'hE2 |=> $stable(power_ctrl_o))
        else $error("soft reset touched power");
    chk_scan_sel: assert property (cmd_w && host_data_i[7:4] == 4'hC
        |=> scan_reverse_o == $past(host_data_i[3]))
        else $error("scan select wrong");
    chk_power_field: assert property (cmd_w && host_data_i[7:3] == 5'b00101
        |=> power_ctrl_o == $past(host_data_i[2:0]))
        else $error("power field wrong");
    chk_contrast_load: assert property (cmd_w && host_data_i[7:5] == 3'b100
        |=> contrast_level_o == $past(host_data_i[4:0]))
        else $error("contrast level wrong");
    chk_contrast_zero: assert property (contrast_suppressed_o == (contrast_level_o == 5'h00))
        else $error("suppress flag wrong");
    chk_save_ground: assert property (outputs_grounded_o
        |-> !follower_en_o && !regulator_en_o && !booster_en_o)
        else $error("supply on in power save");
    chk_standby_sleep: assert property (cmd_w && host_data_i == 8'hE2 && standby_o
        |=> sleep_o && !standby_o)
        else $error("standby not to sleep");
    chk_test_enter: assert property (cmd_w && host_data_i[7:4] == 4'hF |=> test_mode_o)
        else $error("test mode not entered");
    chk_data_no_cmd: assert property (host_wr_i && cmd_data_select_i |=> $stable(rmw_active_o))
        else $error("data write decoded");
endmodule

// file: bench/lcd_mode_command_decoder_bench.sv
`timescale 1ns/1ps
module lcd_mode_command_decoder_bench;
    import lcd_cmd_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    // nets driven by the host model and by the block itself
    wire host_wr_i, host_rd_i, cmd_data_select_i;
    wire [7:0] host_data_i, column_addr_o;
    logic [7:0] power_ctrl_w;
    wire [5:0] start_line_o;
    wire [3:0] page_addr_o;
    wire [2:0] power_ctrl_o;
    wire [4:0] contrast_level_o;
    wire rmw_active_o, scan_reverse_o, display_on_o, entire_on_o, follower_en_o;
    wire regulator_en_o, booster_en_o, contrast_suppressed_o, sleep_o, standby_o;
    wire osc_run_o, outputs_grounded_o, test_mode_o, indicator_on_o;
    wire frame_polarity_out_o, indicator_frame_out_o;
    int mismatches = 0;
    int total_checks = 0;
    int k;

    always #12.5 mclk_i = ~mclk_i;

    // short counts keep blink and frame visible in a few dozen cycles
    lcd_mode_command_decoder #(.BLINK_HALF_CYCLES(8), .FRAME_HALF_CYCLES(3))
    lcd_mode_command_decoder_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .host_wr_i(host_wr_i),
        .host_rd_i(host_rd_i), .cmd_data_select_i(cmd_data_select_i),
        .host_data_i(host_data_i), .start_line_o(start_line_o), .column_addr_o(column_addr_o),
        .page_addr_o(page_addr_o), .rmw_active_o(rmw_active_o), .scan_reverse_o(scan_reverse_o),
        .display_on_o(display_on_o), .entire_on_o(entire_on_o), .power_ctrl_o(power_ctrl_o),
        .follower_en_o(follower_en_o), .regulator_en_o(regulator_en_o),
        .booster_en_o(booster_en_o), .contrast_level_o(contrast_level_o),
        .contrast_suppressed_o(contrast_suppressed_o), .sleep_o(sleep_o),
        .standby_o(standby_o), .osc_run_o(osc_run_o), .outputs_grounded_o(outputs_grounded_o),
        .test_mode_o(test_mode_o), .indicator_on_o(indicator_on_o),
        .frame_polarity_out_o(frame_polarity_out_o),
        .indicator_frame_out_o(indicator_frame_out_o));

    host_model host_model_i (.mclk_i(mclk_i), .host_wr_o(host_wr_i), .host_rd_o(host_rd_i),
        .sel_o(cmd_data_select_i), .data_o(host_data_i));

    ////////////////////////////////////////
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string what);
        chk8({7'h00, got}, {7'h00, exp}, what);
    endtask
    // counts cycles where the indicator electrode is driven against the frame
    task automatic count_inv(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge mclk_i);
            #1;
            if (indicator_frame_out_o !== frame_polarity_out_o) c++;
        end
    endtask
    task automatic apply_reset();
        rst_n_i = 1'b0;
        repeat (4) @(posedge mclk_i);
        #1;
        rst_n_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        #1;
    endtask

    ////////////////////////////////////////
    task automatic test_rmw();
        host_model_i.cmd(8'h12);
        host_model_i.cmd(8'h05);
        host_model_i.dwr();
        chk8(column_addr_o, 8'h26, "column");
        host_model_i.xfer(1'b1, 1'b0, 1'b1, 8'hE0);
        chk1(rmw_active_o, 1'b0, "data byte as cmd");
        host_model_i.cmd(8'hE0);
        host_model_i.drd();
        chk8(column_addr_o, 8'h27, "rmw read");
        host_model_i.dwr();
        host_model_i.dwr();
        chk8(column_addr_o, 8'h29, "rmw writes");
        host_model_i.cmd(8'h9F);
        chk1(rmw_active_o, 1'b1, "rmw kept");
        host_model_i.rmw_close();
        chk8(column_addr_o, 8'h27, "column restored");
        chk1(rmw_active_o, 1'b0, "rmw closed");
        $display("test rmw done");
    endtask

    task automatic test_soft();
        host_model_i.cmd(8'h45);
        host_model_i.cmd(8'hB3);
        host_model_i.cmd(8'hC8);
        host_model_i.cmd(8'h2D);
        chk8({start_line_o, page_addr_o[1:0]}, 8'h17, "start and page set");
        host_model_i.cmd(8'hE2);
        chk8({2'b00, start_line_o} | {4'h0, page_addr_o} | column_addr_o, 8'h00, "addr");
        chk1(scan_reverse_o, 1'b0, "scan");
        chk8({5'h00, power_ctrl_o}, 8'h05, "power kept");
        chk8({3'h0, contrast_level_o}, 8'h1F, "contrast kept");
        $display("test soft reset done");
    endtask

    task automatic test_fields();
        for (int i = 0; i < 8; i++) begin
            host_model_i.cmd(8'h28 | 8'(i));
            power_ctrl_w = {5'h00, follower_en_o, regulator_en_o, booster_en_o};
            chk8({5'h00, power_ctrl_o}, 8'(i), "power field");
            chk8(power_ctrl_w, {5'h00, i[0], i[1], i[2]}, "enables");
        end
        host_model_i.cmd(8'hCF);
        chk1(scan_reverse_o, 1'b1, "reverse");
        host_model_i.cmd(8'hC7);
        chk1(scan_reverse_o, 1'b0, "forward");
        host_model_i.cmd(8'h80);
        chk1(contrast_suppressed_o, 1'b1, "suppressed");
        host_model_i.cmd(8'h81);
        chk8({3'h0, contrast_level_o}, 8'h01, "contrast");
        chk1(contrast_suppressed_o, 1'b0, "not suppressed");
        $display("test fields done");
    endtask

    task automatic test_save();
        host_model_i.cmd(8'hAE);
        host_model_i.cmd(8'hAC);
        host_model_i.cmd(8'hA5);
        chk8({sleep_o, standby_o, osc_run_o, outputs_grounded_o, follower_en_o}, 8'h12, "sleep");
        host_model_i.cmd(8'hA4);
        chk8({sleep_o, osc_run_o, outputs_grounded_o}, 8'h02, "woken");
        host_model_i.cmd(8'hAD);
        host_model_i.cmd(8'hA5);
        chk8({sleep_o, standby_o, outputs_grounded_o}, 8'h03, "standby");
        count_inv(30, k);
        chk1(k > 0, 1'b1, "standby indicator");
        host_model_i.cmd(8'hE2);
        chk8({sleep_o, standby_o}, 8'h02, "standby to sleep");
        host_model_i.cmd(8'hAF);
        chk8({sleep_o, display_on_o}, 8'h01, "display on wakes");
        host_model_i.cmd(8'hA5);
        chk8({sleep_o, standby_o, entire_on_o}, 8'h01, "entire on only");
        host_model_i.cmd(8'hA4);
        chk1(indicator_on_o, 1'b1, "indicator kept");
        $display("test power save done");
    endtask

    task automatic test_blink();
        count_inv(40, k);
        chk1(k > 0 && k < 40, 1'b1, "blinking");
        host_model_i.cmd(8'hAC);
        count_inv(30, k);
        chk8(8'(k), 8'h00, "indicator off");
        $display("test blink done");
    endtask

    task automatic test_mode();
        host_model_i.cmd(8'hF5);
        chk1(test_mode_o, 1'b1, "test entered");
        host_model_i.cmd(8'hE2);
        chk1(test_mode_o, 1'b0, "test left soft");
        host_model_i.cmd(8'hFA);
        apply_reset();
        chk8({test_mode_o, sleep_o, rmw_active_o, contrast_suppressed_o, osc_run_o}, 8'h03,
            "hw reset");
        chk8({5'h00, power_ctrl_o}, 8'h00, "power reset");
        $display("test test mode done");
    endtask

    ////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // the whole sequence needs well under a thousand cycles
    initial begin
        #200_000;
        mismatches++;
        complete_run();
    end

    initial begin
        apply_reset();
        chk8({contrast_suppressed_o, osc_run_o, outputs_grounded_o}, 8'h06, "reset");
        test_rmw();
        test_soft();
        test_fields();
        test_save();
        test_blink();
        test_mode();
        complete_run();
    end
endmodule

bind lcd_mode_command_decoder lcd_cmd_assertions lcd_cmd_assertions_i (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
    .cmd_data_select_i(cmd_data_select_i), .host_data_i(host_data_i),
    .start_line_o(start_line_o), .column_addr_o(column_addr_o), .page_addr_o(page_addr_o),
    .rmw_active_o(rmw_active_o), .scan_reverse_o(scan_reverse_o), .power_ctrl_o(power_ctrl_o),
    .follower_en_o(follower_en_o), .regulator_en_o(regulator_en_o),
    .booster_en_o(booster_en_o), .contrast_level_o(contrast_level_o),
    .contrast_suppressed_o(contrast_suppressed_o), .sleep_o(sleep_o), .standby_o(standby_o),
    .outputs_grounded_o(outputs_grounded_o), .test_mode_o(test_mode_o));

// file: rtl/blink_if.sv
`timescale 1ns/1ps
interface blink_if;
    logic run;
    logic ind_on;
    logic frame_pol;
    logic ind_frame;

    modport gen (input run, input ind_on, output frame_pol, output ind_frame);
    modport ctl (output run, output ind_on, input frame_pol, input ind_frame);
endinterface

// file: rtl/indicator_blink.sv
`timescale 1ns/1ps
module indicator_blink #(
    parameter int unsigned FRAME_HALF = 4000,
    parameter int unsigned BLINK_HALF = 20_000_000
) (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    blink_if.gen      bl
);
    localparam int unsigned FW = $clog2(FRAME_HALF + 1);
    localparam int unsigned BW = $clog2(BLINK_HALF + 1);
    localparam logic [FW-1:0] FRAME_TOP = FW'(FRAME_HALF - 1);
    localparam logic [BW-1:0] BLINK_TOP = BW'(BLINK_HALF - 1);

    typedef struct packed {
        logic [FW-1:0] frame_cnt;
        logic          frame_pol;
        logic [BW-1:0] blink_cnt;
        logic          blink_ph;
        logic          ind_frame;
    } blink_st_t;

    blink_st_t st_r;
    blink_st_t st_nxt;

    // frame polarity runs only while the oscillator runs; the indicator frame
    // follows it in phase while dark and in opposition while lit
    always_comb begin
        st_nxt = st_r;
        if (bl.run) begin
            if (st_r.frame_cnt == FRAME_TOP) begin
                st_nxt.frame_cnt = '0;
                st_nxt.frame_pol = ~st_r.frame_pol;
            end else begin
                st_nxt.frame_cnt = st_r.frame_cnt + 1'b1;
            end
        end
        if (bl.run && bl.ind_on) begin
            if (st_r.blink_cnt == BLINK_TOP) begin
                st_nxt.blink_cnt = '0;
                st_nxt.blink_ph  = ~st_r.blink_ph;
            end else begin
                st_nxt.blink_cnt = st_r.blink_cnt + 1'b1;
            end
        end else if (!bl.ind_on) begin
            st_nxt.blink_cnt = '0;
            st_nxt.blink_ph  = 1'b0;
        end
        st_nxt.ind_frame = st_nxt.frame_pol ^ (bl.ind_on & ~st_nxt.blink_ph);
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bl.frame_pol = st_r.frame_pol;
    assign bl.ind_frame = st_r.ind_frame;
endmodule

// file: rtl/lcd_cmd_pkg.sv
package lcd_cmd_pkg;

    // clock rate and indicator timing
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned BLINK_HALF_MS  = 500;
    localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int unsigned FRAME_HALF_US  = 100;
    localparam int unsigned FRAME_HALF_CYC = CLK_HZ / 1_000_000 * FRAME_HALF_US;

    // exact command bytes
    localparam logic [7:0] CMD_RMW        = 8'hE0;
    localparam logic [7:0] CMD_END        = 8'hEE;
    localparam logic [7:0] CMD_SOFT_RESET = 8'hE2;

    // command families: pattern and mask of the fixed bits
    localparam logic [7:0] PAT_DISP_ONOFF = 8'hAE;
    localparam logic [7:0] MSK_DISP_ONOFF = 8'hFE;
    localparam logic [7:0] PAT_ENTIRE     = 8'hA4;
    localparam logic [7:0] MSK_ENTIRE     = 8'hFE;
    localparam logic [7:0] PAT_INDICATOR  = 8'hAC;
    localparam logic [7:0] MSK_INDICATOR  = 8'hFE;
    localparam logic [7:0] PAT_SCAN_DIR   = 8'hC0;
    localparam logic [7:0] MSK_SCAN_DIR   = 8'hF0;
    localparam logic [7:0] PAT_POWER      = 8'h28;
    localparam logic [7:0] MSK_POWER      = 8'hF8;
    localparam logic [7:0] PAT_CONTRAST   = 8'h80;
    localparam logic [7:0] MSK_CONTRAST   = 8'hE0;
    localparam logic [7:0] PAT_TEST       = 8'hF0;
    localparam logic [7:0] MSK_TEST       = 8'hF0;
    localparam logic [7:0] PAT_START_LINE = 8'h40;
    localparam logic [7:0] MSK_START_LINE = 8'hC0;
    localparam logic [7:0] PAT_PAGE       = 8'hB0;
    localparam logic [7:0] MSK_PAGE       = 8'hF0;
    localparam logic [7:0] PAT_COL_HI     = 8'h10;
    localparam logic [7:0] PAT_COL_LO     = 8'h00;
    localparam logic [7:0] MSK_COL        = 8'hF0;

    // field positions
    localparam int unsigned SEL_BIT      = 0;
    localparam int unsigned SCAN_BIT     = 3;
    localparam int unsigned PWR_FOLLOWER = 0;
    localparam int unsigned PWR_REGULATE = 1;
    localparam int unsigned PWR_BOOSTER  = 2;

    // limits and reset values
    localparam logic [7:0] COL_LAST        = 8'h83;
    localparam logic [5:0] START_LINE_RST  = 6'h00;
    localparam logic [7:0] COL_RST         = 8'h00;
    localparam logic [3:0] PAGE_RST        = 4'h0;
    localparam logic       SCAN_REV_RST    = 1'b0;
    localparam logic [2:0] PWR_RST         = 3'h0;
    localparam logic [4:0] CONTRAST_RST    = 5'h00;
    localparam logic [4:0] CONTRAST_OFF    = 5'h00;

    typedef enum logic [1:0] {
        PS_RUN,
        PS_SLEEP,
        PS_STANDBY
    } psave_t;

endpackage

// file: rtl/lcd_mode_command_decoder.sv
`timescale 1ns/1ps
module lcd_mode_command_decoder
    import lcd_cmd_pkg::*;
#(
    parameter int unsigned BLINK_HALF_CYCLES = BLINK_HALF_CYC,
    parameter int unsigned FRAME_HALF_CYCLES = FRAME_HALF_CYC
) (
    // clock and hardware reset
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    // host write and read strobes, already on mclk_i
    input  wire logic       host_wr_i,
    input  wire logic       host_rd_i,
    input  wire logic       cmd_data_select_i,
    input  wire logic [7:0] host_data_i,
    // addressing state
    output logic [5:0]      start_line_o,
    output logic [7:0]      column_addr_o,
    output logic [3:0]      page_addr_o,
    output logic            rmw_active_o,
    // common scan and display mode
    output logic            scan_reverse_o,
    output logic            display_on_o,
    output logic            entire_on_o,
    // power circuits and contrast
    output logic [2:0]      power_ctrl_o,
    output logic            follower_en_o,
    output logic            regulator_en_o,
    output logic            booster_en_o,
    output logic [4:0]      contrast_level_o,
    output logic            contrast_suppressed_o,
    // power save and test
    output logic            sleep_o,
    output logic            standby_o,
    output logic            osc_run_o,
    output logic            outputs_grounded_o,
    output logic            test_mode_o,
    // static indicator
    output logic            indicator_on_o,
    output logic            frame_polarity_out_o,
    output logic            indicator_frame_out_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // reset release

    // the pin may let go at any moment; release it through two flops
    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [5:0] start_line;
        logic [7:0] col;
        logic [7:0] col_saved;
        logic [3:0] page;
        logic       scan_rev;
        logic [2:0] pwr;
        logic [4:0] contrast;
        logic       ind_on;
        logic       disp_on;
        logic       entire_on;
        logic       rmw;
        logic       test;
        psave_t     ps;
    } ctl_st_t;

    localparam ctl_st_t CTL_RST = '{
        start_line: START_LINE_RST,
        col:        COL_RST,
        col_saved:  COL_RST,
        page:       PAGE_RST,
        scan_rev:   SCAN_REV_RST,
        pwr:        PWR_RST,
        contrast:   CONTRAST_RST,
        ind_on:     1'b0,
        disp_on:    1'b0,
        entire_on:  1'b0,
        rmw:        1'b0,
        test:       1'b0,
        ps:         PS_RUN
    };

    ctl_st_t st_r;
    ctl_st_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // decode

    logic       cmd_stb;
    logic       data_wr;
    logic       data_rd;
    logic [7:0] cb;

    // select low marks a command, high marks display data
    assign cmd_stb = host_wr_i & ~cmd_data_select_i;
    assign data_wr = host_wr_i & cmd_data_select_i;
    assign data_rd = host_rd_i & cmd_data_select_i;
    assign cb      = host_data_i;

    logic is_rmw;
    logic is_end;
    logic is_srst;
    logic is_disp;
    logic is_entire;
    logic is_ind;
    logic is_scan;
    logic is_pwr;
    logic is_contrast;
    logic is_test;
    logic is_start;
    logic is_page;
    logic is_col_hi;
    logic is_col_lo;

    // one-hot family match of the command byte
    always_comb begin
        is_rmw      = cmd_stb && cb == CMD_RMW;
        is_end      = cmd_stb && cb == CMD_END;
        is_srst     = cmd_stb && cb == CMD_SOFT_RESET;
        is_disp     = cmd_stb && (cb & MSK_DISP_ONOFF) == PAT_DISP_ONOFF;
        is_entire   = cmd_stb && (cb & MSK_ENTIRE) == PAT_ENTIRE;
        is_ind      = cmd_stb && (cb & MSK_INDICATOR) == PAT_INDICATOR;
        is_scan     = cmd_stb && (cb & MSK_SCAN_DIR) == PAT_SCAN_DIR;
        is_pwr      = cmd_stb && (cb & MSK_POWER) == PAT_POWER;
        is_contrast = cmd_stb && (cb & MSK_CONTRAST) == PAT_CONTRAST;
        is_test     = cmd_stb && (cb & MSK_TEST) == PAT_TEST;
        is_start    = cmd_stb && (cb & MSK_START_LINE) == PAT_START_LINE;
        is_page     = cmd_stb && (cb & MSK_PAGE) == PAT_PAGE;
        is_col_hi   = cmd_stb && (cb & MSK_COL) == PAT_COL_HI;
        is_col_lo   = cmd_stb && (cb & MSK_COL) == PAT_COL_LO;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_nxt = st_r;

        // column counter: reads stall while read-modify-write is open
        if (data_wr || (data_rd && !st_r.rmw)) begin
            if (st_r.col < COL_LAST) begin
                st_nxt.col = st_r.col + 8'h01;
            end
        end

        // addressing commands; a column set during read-modify-write is
        // dropped so the saved return address cannot be corrupted
        if (is_start) begin
            st_nxt.start_line = cb[5:0];
        end
        if (is_page) begin
            st_nxt.page = cb[3:0];
        end
        if (is_col_hi && !st_r.rmw) begin
            st_nxt.col = {cb[3:0], st_r.col[3:0]};
        end
        if (is_col_lo && !st_r.rmw) begin
            st_nxt.col = {st_r.col[7:4], cb[3:0]};
        end

        // read-modify-write entry saves the column, end restores it;
        // every other command leaves the mode open
        if (is_rmw) begin
            st_nxt.rmw       = 1'b1;
            st_nxt.col_saved = st_r.col;
        end
        if (is_end && st_r.rmw) begin
            st_nxt.rmw = 1'b0;
            st_nxt.col = st_r.col_saved;
        end

        // scan direction: only bit 3 matters, low bits are ignored
        if (is_scan) begin
            st_nxt.scan_rev = cb[SCAN_BIT];
        end

        // power field and contrast level
        if (is_pwr) begin
            st_nxt.pwr = cb[2:0];
        end
        if (is_contrast) begin
            st_nxt.contrast = cb[4:0];
        end

        // indicator is touched by its own command and nothing else
        if (is_ind) begin
            st_nxt.ind_on = cb[SEL_BIT];
        end

        // display on/off and entire display, with power save entry and exit
        if (is_disp) begin
            st_nxt.disp_on = cb[SEL_BIT];
            if (cb[SEL_BIT]) begin
                st_nxt.ps = PS_RUN;
            end
        end
        if (is_entire) begin
            st_nxt.entire_on = cb[SEL_BIT];
            if (!cb[SEL_BIT]) begin
                st_nxt.ps = PS_RUN;
            end else if (!st_r.disp_on) begin
                st_nxt.ps = st_r.ind_on ? PS_STANDBY : PS_SLEEP;
            end
        end

        // test mode latches on any byte of the F family
        if (is_test) begin
            st_nxt.test = 1'b1;
        end

        // soft reset: addressing and scan back to initial values, power
        // field and contrast held; display memory lives outside this block
        if (is_srst) begin
            st_nxt.start_line = START_LINE_RST;
            st_nxt.col        = COL_RST;
            st_nxt.page       = PAGE_RST;
            st_nxt.scan_rev   = SCAN_REV_RST;
            st_nxt.test       = 1'b0;
            case (st_r.ps)
                PS_STANDBY: st_nxt.ps = PS_SLEEP;
                PS_SLEEP:   st_nxt.ps = PS_SLEEP;
                PS_RUN:     st_nxt.ps = PS_RUN;
                default:    st_nxt.ps = PS_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register

    // hardware reset is the only path that clears power, display modes and save state; soft reset also clears test mode
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= CTL_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // indicator and frame drive

    blink_if bl();

    // oscillator stops in sleep, so frame and blink freeze there
    assign bl.run    = (st_r.ps != PS_SLEEP);
    assign bl.ind_on = st_r.ind_on;

    indicator_blink #(
        .FRAME_HALF (FRAME_HALF_CYCLES),
        .BLINK_HALF (BLINK_HALF_CYCLES)
    ) u_blink (
        .mclk_i (mclk_i),
        .rst_n_i(rst_n),
        .bl     (bl)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    // addressing and mode state straight from the struct register
    assign start_line_o   = st_r.start_line;
    assign column_addr_o  = st_r.col;
    assign page_addr_o    = st_r.page;
    assign rmw_active_o   = st_r.rmw;
    assign scan_reverse_o = st_r.scan_rev;
    assign display_on_o   = st_r.disp_on;
    assign entire_on_o    = st_r.entire_on;
    assign test_mode_o    = st_r.test;
    assign indicator_on_o = st_r.ind_on;

    // the stored field stays intact in power save, only its effect is cut
    assign power_ctrl_o   = st_r.pwr;
    assign follower_en_o  = st_r.pwr[PWR_FOLLOWER] && st_r.ps == PS_RUN;
    assign regulator_en_o = st_r.pwr[PWR_REGULATE] && st_r.ps == PS_RUN;
    assign booster_en_o   = st_r.pwr[PWR_BOOSTER] && st_r.ps == PS_RUN;

    assign contrast_level_o      = st_r.contrast;
    assign contrast_suppressed_o = (st_r.contrast == CONTRAST_OFF);

    // power save: driver outputs tied to ground in either save mode
    assign sleep_o            = (st_r.ps == PS_SLEEP);
    assign standby_o          = (st_r.ps == PS_STANDBY);
    assign osc_run_o          = (st_r.ps != PS_SLEEP);
    assign outputs_grounded_o = (st_r.ps != PS_RUN);

    // frame outputs keep toggling in standby so the indicator stays lit
    assign frame_polarity_out_o  = bl.frame_pol;
    assign indicator_frame_out_o = bl.ind_frame;

endmodule
